// ==== pkg/amd_pkg.sv ====
// Package for the addressing-mode and instruction-class decoder
package amd_pkg;

  // ----------------------------------------------------------------
  // Operand addressing modes (hex codes written out)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AMD_M_INH = 3'h0,  // No operand byte, no address
    AMD_M_IMM = 3'h1,  // Literal data byte
    AMD_M_DIR = 3'h2,  // Low address byte, page zero
    AMD_M_EXT = 3'h3,  // Full 16-bit address
    AMD_M_IX  = 3'h4,  // Index register only
    AMD_M_IX1 = 3'h5,  // Index plus 8-bit offset
    AMD_M_IX2 = 3'h6,  // Index plus 16-bit offset
    AMD_M_REL = 3'h7   // Signed branch offset
  } amd_mode_t;

  // ----------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AMD_C_REGMEM = 3'h0,  // Register/memory
    AMD_C_RMW    = 3'h1,  // Read-modify-write
    AMD_C_JMPBR  = 3'h2,  // Jump/branch
    AMD_C_BIT    = 3'h3,  // Bit manipulation
    AMD_C_CTRL   = 3'h4   // Control
  } amd_class_t;

  // ----------------------------------------------------------------
  // Fetch sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AMD_S_OPC = 2'h0,  // Waiting for an opcode byte
    AMD_S_B1  = 2'h1,  // Waiting for first operand byte
    AMD_S_B2  = 2'h2   // Waiting for second operand byte
  } amd_state_t;

  // ----------------------------------------------------------------
  // Opcode map fields and fixed values
  // ----------------------------------------------------------------
  localparam logic [3:0] AMD_HI_BITBR = 4'h0;  // Bit test and branch row
  localparam logic [3:0] AMD_HI_BITSC = 4'h1;  // Bit set/clear row
  localparam logic [3:0] AMD_HI_REL = 4'h2;  // Relative branch row
  localparam logic [3:0] AMD_HI_IMM = 4'hA;  // Immediate row
  localparam logic [3:0] AMD_LO_STA = 4'h7;  // Store accumulator column
  localparam logic [3:0] AMD_LO_STX = 4'hF;  // Store index column
  localparam logic [3:0] AMD_LO_JMP = 4'hC;  // Jump column
  localparam logic [3:0] AMD_LO_JSR = 4'hD;  // Jump to subroutine column
  localparam logic [3:0] AMD_LO_TST = 4'hD;  // Test negative/zero column
  localparam logic [7:0] AMD_OP_MUL = 8'h42;  // Multiply opcode
  localparam logic [7:0] AMD_OP_BSR = 8'hAD;  // Branch to subroutine
  localparam logic [7:0] AMD_ZERO_HI = 8'h00;  // Forced high address byte
  localparam logic [15:0] AMD_IX1_MAX = 16'h01FE;  // Top of 8-bit indexed span
  localparam logic [1:0] AMD_LEN_1 = 2'h1;  // One-byte instruction
  localparam logic [1:0] AMD_LEN_2 = 2'h2;  // Two-byte instruction
  localparam logic [1:0] AMD_LEN_3 = 2'h3;  // Three-byte instruction

  // ----------------------------------------------------------------
  // Decoded instruction as handed to the execution logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opcode;     // Opcode byte
    amd_mode_t mode;        // Addressing mode
    amd_class_t cls;        // Instruction class
    logic [1:0] len;        // Length in bytes
    logic [15:0] ea;        // Effective operand address
    logic ea_used;          // Memory operand address is meaningful
    logic mem_write;        // Operand is written back to memory
    logic is_branch;        // Conditional/relative branch
    logic taken;            // Branch condition was true
    logic [15:0] next_pc;   // Address of next instruction to fetch
    logic [15:0] opc_pc;    // Address of the opcode byte
  } amd_info_t;

endpackage

// ==== verilog/amd_decode.sv ====
// Addressing-mode decoder and effective address generator
// Contract
// - Exactly eight operand addressing modes supported
// - Inherent: one byte, no address
// - Immediate: two bytes, literal data, no address
// - Direct: two bytes, high address byte zero
// - Bit branches: three bytes, direct plus relative
// - Extended: three bytes, high then low
// - Indexed no offset: one byte, page zero
// - Indexed 8-bit: index plus offset, untruncated
// - Indexed 16-bit: three bytes, high offset first
// - Relative only for branches, taken adds offset
// - Offset sign-extended, from next instruction address
// - Every instruction gets one of five classes
// - Register/memory takes second operand from memory
// - Register/memory class holds the fifteen listed operations
// - Read-modify-write writes back, except test_negative_zero and the inherent register forms
`timescale 1ns/1ps
`default_nettype none

module amd_decode (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic byte_vld_i,
  input wire logic [7:0] byte_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] idx_i,
  input wire logic cond_i,
  output logic busy_o,
  output logic done_o,
  output var amd_pkg::amd_info_t info_o
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    amd_pkg::amd_state_t st;  // Sequencer state
    logic [7:0] op;           // Captured opcode
    logic [7:0] b1;           // First operand byte
    logic [7:0] b2;           // Second operand byte
    logic [7:0] x;            // Index captured with the opcode
    logic [15:0] pc0;         // Opcode address
    logic busy;               // Instruction in progress
    logic done;               // One-cycle completion pulse
    amd_pkg::amd_info_t info; // Decoded result, held until next
  } amd_reg_t;

  amd_reg_t q;  // Registered state
  amd_reg_t d;  // Next state

  // ----------------------------------------------------------------
  // Opcode map decode
  // ----------------------------------------------------------------

  // Mode from the opcode row; BSR sits in the immediate row
  // eight modes from opcode
  function automatic amd_pkg::amd_mode_t mode_of(input logic [7:0] op);
    case (op[7:4])
      4'h0, 4'h1, 4'h3, 4'hB: mode_of = amd_pkg::AMD_M_DIR;
      4'h2: mode_of = amd_pkg::AMD_M_REL;
      4'h4, 4'h5, 4'h8, 4'h9: mode_of = amd_pkg::AMD_M_INH;
      4'h6, 4'hE: mode_of = amd_pkg::AMD_M_IX1;
      4'h7, 4'hF: mode_of = amd_pkg::AMD_M_IX;
      4'hA: mode_of = (op == amd_pkg::AMD_OP_BSR) ? amd_pkg::AMD_M_REL : amd_pkg::AMD_M_IMM;
      4'hC: mode_of = amd_pkg::AMD_M_EXT;
      4'hD: mode_of = amd_pkg::AMD_M_IX2;
      default: mode_of = amd_pkg::AMD_M_INH;
    endcase
  endfunction

  // Byte count; the bit-branch row adds an offset to direct
  function automatic logic [1:0] len_of(input logic [7:0] op);
    case (mode_of(op))
      amd_pkg::AMD_M_INH, amd_pkg::AMD_M_IX: len_of = amd_pkg::AMD_LEN_1;
      amd_pkg::AMD_M_EXT, amd_pkg::AMD_M_IX2: len_of = amd_pkg::AMD_LEN_3;
      amd_pkg::AMD_M_DIR: begin
        len_of = (op[7:4] == amd_pkg::AMD_HI_BITBR) ? amd_pkg::AMD_LEN_3 : amd_pkg::AMD_LEN_2;
      end
      default: len_of = amd_pkg::AMD_LEN_2;
    endcase
  endfunction

  // Class from row and column
  // five-way classification
  function automatic amd_pkg::amd_class_t class_of(input logic [7:0] op);
    case (op[7:4])
      4'h0, 4'h1: class_of = amd_pkg::AMD_C_BIT;
      4'h2: class_of = amd_pkg::AMD_C_JMPBR;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: begin
        class_of = (op == amd_pkg::AMD_OP_MUL) ? amd_pkg::AMD_C_REGMEM : amd_pkg::AMD_C_RMW;
      end
      4'h8, 4'h9: class_of = amd_pkg::AMD_C_CTRL;
      default: begin
        // all other columns of rows A..F are register/memory
        if (op[3:0] == amd_pkg::AMD_LO_JMP || op[3:0] == amd_pkg::AMD_LO_JSR) begin
          class_of = amd_pkg::AMD_C_JMPBR;
        end else begin
          class_of = amd_pkg::AMD_C_REGMEM;
        end
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Result assembly once the last byte is in
  // ----------------------------------------------------------------
  function automatic amd_pkg::amd_info_t finish(input logic [7:0] op, input logic [7:0] b1,
                                                input logic [7:0] b2, input logic [7:0] x,
                                                input logic [15:0] pc0, input logic cond);
    amd_pkg::amd_info_t r;
    logic [15:0] seq_pc;
    logic [7:0] off;
    r = '0;
    r.opcode = op;
    r.mode = mode_of(op);
    r.cls = class_of(op);
    r.len = len_of(op);
    r.opc_pc = pc0;
    // Fall-through address, wrapping at the top of memory
    seq_pc = pc0 + {14'h0000, r.len};
    // Bit branches carry their offset in the third byte
    off = (op[7:4] == amd_pkg::AMD_HI_BITBR) ? b2 : b1;
    case (r.mode)
      amd_pkg::AMD_M_INH, amd_pkg::AMD_M_IMM, amd_pkg::AMD_M_REL: r.ea = 16'h0000;
      amd_pkg::AMD_M_DIR: r.ea = {amd_pkg::AMD_ZERO_HI, b1};
      amd_pkg::AMD_M_EXT: r.ea = {b1, b2};
      amd_pkg::AMD_M_IX: r.ea = {amd_pkg::AMD_ZERO_HI, x};
      amd_pkg::AMD_M_IX1: r.ea = {8'h00, x} + {8'h00, b1};
      // two-byte offset, high byte fetched first
      default: r.ea = {b1, b2} + {8'h00, x};
    endcase
    // memory operand for all addressed modes
    r.ea_used = (r.mode == amd_pkg::AMD_M_DIR) || (r.mode == amd_pkg::AMD_M_EXT) ||
                (r.mode == amd_pkg::AMD_M_IX) || (r.mode == amd_pkg::AMD_M_IX1) ||
                (r.mode == amd_pkg::AMD_M_IX2);
    // RMW write-back unless test column or register form; bit set/clear and non-immediate stores always write
    r.mem_write = ((r.cls == amd_pkg::AMD_C_RMW) && (r.mode != amd_pkg::AMD_M_INH) &&
                   (op[3:0] != amd_pkg::AMD_LO_TST)) ||
                  (op[7:4] == amd_pkg::AMD_HI_BITSC) ||
                  ((r.cls == amd_pkg::AMD_C_REGMEM) && (op[7:4] != amd_pkg::AMD_HI_IMM) &&
                   ((op[3:0] == amd_pkg::AMD_LO_STA) || (op[3:0] == amd_pkg::AMD_LO_STX)));
    // only relative-offset branches take the condition
    r.is_branch = (r.mode == amd_pkg::AMD_M_REL) || (op[7:4] == amd_pkg::AMD_HI_BITBR);
    r.taken = r.is_branch && cond;
    if (r.taken) begin
      // sign-extended offset from the following address
      r.next_pc = seq_pc + {{8{off[7]}}, off};
    end else if ((r.cls == amd_pkg::AMD_C_JMPBR) && r.ea_used) begin
      // Jumps continue at their operand address
      r.next_pc = r.ea;
    end else begin
      r.next_pc = seq_pc;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bytes are taken only on byte_vld_i; the fetch side paces the
  // sequencer, so there is no stall port of our own.
  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      amd_pkg::AMD_S_OPC: begin
        if (byte_vld_i) begin
          d.op = byte_i;
          d.pc0 = pc_i;
          d.x = idx_i;
          if (len_of(byte_i) == amd_pkg::AMD_LEN_1) begin
            d.info = finish(byte_i, 8'h00, 8'h00, idx_i, pc_i, cond_i);
            d.done = 1'b1;
          end else begin
            d.st = amd_pkg::AMD_S_B1;
            d.busy = 1'b1;
          end
        end
      end
      amd_pkg::AMD_S_B1: begin
        if (byte_vld_i) begin
          d.b1 = byte_i;
          if (len_of(q.op) == amd_pkg::AMD_LEN_2) begin
            d.info = finish(q.op, byte_i, 8'h00, q.x, q.pc0, cond_i);
            d.done = 1'b1;
            d.st = amd_pkg::AMD_S_OPC;
            d.busy = 1'b0;
          end else begin
            d.st = amd_pkg::AMD_S_B2;
          end
        end
      end
      amd_pkg::AMD_S_B2: begin
        if (byte_vld_i) begin
          d.b2 = byte_i;
          d.info = finish(q.op, q.b1, byte_i, q.x, q.pc0, cond_i);
          d.done = 1'b1;
          d.st = amd_pkg::AMD_S_OPC;
          d.busy = 1'b0;
        end
      end
      default: begin
        // Unreachable code recovers to opcode fetch
        d.st = amd_pkg::AMD_S_OPC;
        d.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register; reset restarts at opcode fetch
  // ----------------------------------------------------------------
  // Reset loads constants only, so no data path feeds the clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the record, so no decode glitch reaches
  // the execution side
  assign busy_o = q.busy;
  assign done_o = q.done;
  assign info_o = q.info;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Checks sample the registered outputs in the done cycle, while q still
  // holds the operand bytes and index of the instruction just finished
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  inh_len_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_INH |->
    info_o.len == amd_pkg::AMD_LEN_1 && !info_o.ea_used) else $error("inherent length wrong");
  imm_noaddr_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_IMM |->
    info_o.len == amd_pkg::AMD_LEN_2 && !info_o.ea_used) else $error("immediate form wrong");
  dir_page_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_DIR |->
    info_o.ea == {8'h00, q.b1}) else $error("direct address wrong");
  bitbr_len_a: assert property (done_o && info_o.opcode[7:4] == 4'h0 |->
    info_o.len == amd_pkg::AMD_LEN_3 && info_o.is_branch) else $error("bit branch form wrong");
  ext_order_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_EXT |->
    info_o.ea == {q.b1, q.b2}) else $error("extended byte order wrong");
  ix_page_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_IX |->
    info_o.ea == {8'h00, q.x} && info_o.len == amd_pkg::AMD_LEN_1) else $error("indexed wrong");
  ix1_span_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_IX1 |->
    info_o.ea <= amd_pkg::AMD_IX1_MAX && info_o.ea == {8'h00, q.x} + {8'h00, q.b1})
    else $error("8-bit indexed sum wrong");
  ix2_wrap_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_IX2 |->
    info_o.ea == 16'({q.b1, q.b2} + {8'h00, q.x})) else $error("16-bit indexed sum wrong");
  rel_target_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_REL &&
    info_o.taken |-> info_o.next_pc == 16'(info_o.opc_pc + 16'h0002 + {{8{q.b1[7]}}, q.b1}))
    else $error("relative target wrong");
  rel_fall_a: assert property (done_o && info_o.is_branch && !info_o.taken |->
    info_o.next_pc == 16'(info_o.opc_pc + {14'h0000, info_o.len}))
    else $error("fallthrough wrong");
  tst_nowrite_a: assert property (done_o && info_o.cls == amd_pkg::AMD_C_RMW &&
    info_o.opcode[3:0] == 4'hD |-> !info_o.mem_write) else $error("test wrote back");
  seq_done_a: assert property (q.st == amd_pkg::AMD_S_B2 && byte_vld_i |=>
    done_o && info_o.len == amd_pkg::AMD_LEN_3 && !busy_o) else $error("third byte not final");

  // Lengths and operand forms per mode and class
  dir_len_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_DIR &&
    info_o.opcode[7:4] != amd_pkg::AMD_HI_BITBR |-> info_o.len == amd_pkg::AMD_LEN_2)
    else $error("direct length wrong");
  ext_len_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_EXT |->
    info_o.len == amd_pkg::AMD_LEN_3 && info_o.ea_used) else $error("extended length wrong");
  ix2_len_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_IX2 |->
    info_o.len == amd_pkg::AMD_LEN_3 && info_o.ea_used)
    else $error("offset index length wrong");
  rel_noaddr_a: assert property (done_o && info_o.mode == amd_pkg::AMD_M_REL |->
    info_o.is_branch && !info_o.ea_used && info_o.cls == amd_pkg::AMD_C_JMPBR)
    else $error("relative form wrong");
  regmem_mem_a: assert property (done_o && info_o.cls == amd_pkg::AMD_C_REGMEM &&
    info_o.mode != amd_pkg::AMD_M_IMM && info_o.mode != amd_pkg::AMD_M_INH |-> info_o.ea_used)
    else $error("register/memory operand not addressed");
  cls_five_a: assert property (done_o |->
    info_o.cls inside {amd_pkg::AMD_C_REGMEM, amd_pkg::AMD_C_RMW, amd_pkg::AMD_C_JMPBR,
    amd_pkg::AMD_C_BIT, amd_pkg::AMD_C_CTRL}) else $error("class out of range");

  // Scenarios the byte stream must reach at least once
  rel_taken_c: cover property (done_o && info_o.mode == amd_pkg::AMD_M_REL && info_o.taken);
  ix2_wrap_c: cover property (done_o && info_o.mode == amd_pkg::AMD_M_IX2 &&
    info_o.ea < {q.b1, q.b2});
  bitbr_c: cover property (done_o && info_o.cls == amd_pkg::AMD_C_BIT && info_o.is_branch);
  rmw_c: cover property (done_o && info_o.cls == amd_pkg::AMD_C_RMW && info_o.mem_write);
  ix1_high_c: cover property (done_o && info_o.mode == amd_pkg::AMD_M_IX1 && info_o.ea[8]);

endmodule

`default_nettype wire

// ==== verif/amd_prog_mem.sv ====
// Program memory model that streams bytes to the decoder
`timescale 1ns/1ps
`default_nettype none

module amd_prog_mem #(
  parameter logic [15:0] BASE = 16'hFF00  // First fetch address, near the top to force wrap
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic stall_i,
  output logic byte_vld_o,
  output logic [7:0] byte_o,
  output logic [15:0] pc_o
);
  logic [7:0] mem [256];  // Program image, loaded by the bench
  logic [15:0] nxt_q;  // Address of the next byte to offer

  // ----------------------------------------------------------------
  // Fetch stream
  // ----------------------------------------------------------------
  // Idle cycles scramble the lines so a stale byte is never mistaken for data
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nxt_q <= BASE;
      byte_vld_o <= 1'b0;
      byte_o <= 8'h00;
      pc_o <= 16'h0000;
    end else if (run_i && !stall_i && nxt_q[7:0] != 8'hFF) begin
      byte_vld_o <= 1'b1;
      byte_o <= mem[nxt_q[7:0]];
      pc_o <= nxt_q;
      nxt_q <= nxt_q + 16'h0001;
    end else begin
      byte_vld_o <= 1'b0;
      byte_o <= ~byte_o;
      pc_o <= ~pc_o;
    end
  end
endmodule

`default_nettype wire

// ==== verif/amd_decode_bench.sv ====
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/1ps
`default_nettype none

module amd_decode_bench;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] idx_i = 8'h00;
  logic cond_i = 1'b0;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic byte_vld;
  logic [7:0] byte_v;
  logic [15:0] pc_v;
  logic busy_o;
  logic done_o;
  amd_pkg::amd_info_t info_o;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  // Tracker state: opcode, operands and what is still owed
  logic [7:0] op, b1, b2, x;
  logic [15:0] pc0;
  logic [1:0] rem = 2'h0;
  logic mid = 1'b0;
  logic dn = 1'b0;
  amd_pkg::amd_info_t exq [$];
  // Per opcode row: mode, class, length
  localparam logic [7:0] ROW [16] = '{8'h4F, 8'h4E, 8'hEA, 8'h46, 8'h05, 8'h05, 8'hA6, 8'h85,
    8'h11, 8'h11, 8'h22, 8'h42, 8'h63, 8'hC3, 8'hA2, 8'h81};

  always #5 clk_i = ~clk_i;

  amd_prog_mem pm (.clk_i(clk_i), .arst_n_i(arst_n_i), .run_i(run), .stall_i(stall),
    .byte_vld_o(byte_vld), .byte_o(byte_v), .pc_o(pc_v));
  amd_decode dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .byte_vld_i(byte_vld), .byte_i(byte_v),
    .pc_i(pc_v), .idx_i(idx_i), .cond_i(cond_i), .busy_o(busy_o), .done_o(done_o),
    .info_o(info_o));

  function automatic logic [1:0] len_of(logic [7:0] o);
    return ROW[o[7:4]][1:0];
  endfunction

  // Opcodes whose store or jump reading is left open are kept out
  function automatic logic bad(logic [7:0] o);
    logic [3:0] h;
    h = o[7:4];
    return o == 8'hAC || o == 8'hA7 || o == 8'hAF || (o[2:0] == 3'h7 &&
      (h == 4'h0 || h == 4'h2 || h == 4'h4 || h == 4'h5 || h == 4'h8 || h == 4'h9));
  endfunction

  function automatic amd_pkg::amd_info_t exp_info(logic [7:0] o, logic [7:0] p1,
      logic [7:0] p2, logic [15:0] pc, logic [7:0] ix, logic c);
    amd_pkg::amd_info_t e;
    logic [3:0] h;
    logic [7:0] off;
    e = '0;
    h = o[7:4];
    e.opcode = o;
    e.opc_pc = pc;
    e.mode = amd_pkg::amd_mode_t'(ROW[h][7:5]);
    e.cls = amd_pkg::amd_class_t'(ROW[h][4:2]);
    e.len = ROW[h][1:0];
    if (o == amd_pkg::AMD_OP_MUL) e.cls = amd_pkg::AMD_C_REGMEM;
    if (h >= 4'hA && o[3:1] == 3'h6) e.cls = amd_pkg::AMD_C_JMPBR;
    if (o == amd_pkg::AMD_OP_BSR) e.mode = amd_pkg::AMD_M_REL;
    e.is_branch = h == 4'h0 || h == 4'h2 || o == amd_pkg::AMD_OP_BSR;
    e.taken = e.is_branch & c;
    case (e.mode)
      amd_pkg::AMD_M_DIR: e.ea = {8'h00, p1};
      amd_pkg::AMD_M_EXT: e.ea = {p1, p2};
      amd_pkg::AMD_M_IX: e.ea = {8'h00, ix};
      amd_pkg::AMD_M_IX1: e.ea = {8'h00, p1} + {8'h00, ix};
      amd_pkg::AMD_M_IX2: e.ea = {p1, p2} + {8'h00, ix};
      default: e.ea = 16'h0000;
    endcase
    e.ea_used = !(e.mode inside {amd_pkg::AMD_M_INH, amd_pkg::AMD_M_IMM, amd_pkg::AMD_M_REL});
    e.mem_write = h == 4'h1 || ((h == 4'h3 || h[3:1] == 3'h3) && o[3:0] != 4'hD) ||
      (h >= 4'hB && o[2:0] == 3'h7);
    off = (h == 4'h0) ? p2 : p1;
    e.next_pc = pc + {14'h0000, e.len};
    if (e.taken) e.next_pc = e.next_pc + {{8{off[7]}}, off};
    else if (h >= 4'hB && o[3:1] == 3'h6) e.next_pc = e.ea;
    return e;
  endfunction

  task automatic cmp_val(string nm, logic [15:0] ex, logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic cmp_bit(string nm, logic ex, logic got);
    num_checks++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", nm, ex, got);
    end
  endtask

  task automatic check_info(amd_pkg::amd_info_t e);
    cmp_val("opcode", {8'h00, e.opcode}, {8'h00, info_o.opcode});
    cmp_val("mode", {13'h0000, e.mode}, {13'h0000, info_o.mode});
    cmp_val("cls", {13'h0000, e.cls}, {13'h0000, info_o.cls});
    cmp_val("len", {14'h0000, e.len}, {14'h0000, info_o.len});
    cmp_val("ea", e.ea, info_o.ea);
    cmp_bit("ea_used", e.ea_used, info_o.ea_used);
    cmp_bit("mem_write", e.mem_write, info_o.mem_write);
    cmp_bit("is_branch", e.is_branch, info_o.is_branch);
    cmp_bit("taken", e.taken, info_o.taken);
    cmp_val("next_pc", e.next_pc, info_o.next_pc);
    cmp_val("opc_pc", e.opc_pc, info_o.opc_pc);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Random operand inputs and fetch gaps, all off the sampling edge by NBA
  always @(posedge clk_i) begin
    idx_i <= 8'($urandom);
    cond_i <= 1'($urandom);
    stall <= slow && ($urandom_range(2) == 0);
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  // Reference tracker: splits the byte stream into whole instructions
  always @(posedge clk_i) begin
    if (arst_n_i) begin
      cmp_bit("busy", mid, busy_o);
      cmp_bit("done", dn, done_o);
      if (done_o === 1'b1 && exq.size() > 0) check_info(exq.pop_front());
    end
    dn = 1'b0;
    if (!arst_n_i) begin
      rem = 2'h0;
      mid = 1'b0;
      exq.delete();
    end else if (byte_vld === 1'b1) begin
      if (rem == 2'h0) begin
        op = byte_v;
        pc0 = pc_v;
        x = idx_i;
        b1 = 8'h00;
        b2 = 8'h00;
        rem = len_of(byte_v) - 2'h1;
      end else begin
        if (rem == len_of(op) - 2'h1) b1 = byte_v;
        else b2 = byte_v;
        rem = rem - 2'h1;
      end
      if (rem == 2'h0) begin
        exq.push_back(exp_info(op, b1, b2, pc0, x, cond_i));
        dn = 1'b1;
      end
      mid = rem != 2'h0;
    end
  end

  initial begin
    int a;
    logic [7:0] o;
    logic [7:0] cb [$];
    void'($urandom(32'hC9696D69));
    // Corner cases first: walk example, offset limits, wraps, test and jump forms
    cb = '{8'hC6, 8'h12, 8'h34, 8'h9D, 8'h00, 8'h55, 8'h80, 8'h20, 8'h7F, 8'h21, 8'h80,
      8'hAD, 8'h80, 8'hD6, 8'hFF, 8'hFF, 8'h3D, 8'h10, 8'h42, 8'hCC, 8'h12, 8'h34,
      8'h17, 8'h20, 8'hE6, 8'hFF, 8'hF6, 8'hA6, 8'h5A};
    a = 0;
    foreach (cb[i]) pm.mem[a + i] = cb[i];
    a = cb.size();
    while (a < 250) begin
      do o = 8'($urandom); while (bad(o));
      pm.mem[a] = o;
      for (int k = 1; k < 3; k++) pm.mem[a + k] = 8'($urandom);
      a = a + int'(len_of(o));
    end
    while (a < 256) begin
      pm.mem[a] = 8'h9D;
      a++;
    end
    // Run 0 prompt, run 1 slow and cut by reset, run 2 slow to the end
    for (int r = 0; r < 3; r++) begin
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      run <= 1'b0;
      repeat (5) @(posedge clk_i);
      cmp_bit("reset_quiet", 1'b1, info_o === '0 && done_o === 1'b0 && busy_o === 1'b0);
      arst_n_i <= 1'b1;
      run <= 1'b1;
      slow <= r != 0;
      if (r == 1) repeat (60) @(posedge clk_i);
      else begin
        for (int w = 0; w < 4000 && pm.nxt_q[7:0] != 8'hFF; w++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        cmp_val("pending", 16'h0000, 16'(exq.size()));
      end
    end
    close_out();
  end
endmodule

`default_nettype wire
